// file: dv/pmsc_checker.sv
// Port-level assertions for the power management status block.
module pmsc_checker (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       undervolt_irq,
  input wire logic       undervolt_reset,
  input wire logic       reference_buffer_enable,
  input wire logic       detect_trip_select,
  input wire logic       warning_trip_select,
  input wire logic       deep_sleep_allow,
  input wire logic       deep_sleep_kind_select
);
  logic pd_used_reg;
  // Notes that the write-once power-down fields were used up.
  always_ff @(posedge clock) begin
    if (!rstn)
      pd_used_reg <= 1'b0;
    else if (reg_write && reg_addr == 3'h1)
      pd_used_reg <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("Read data outside its slot.");
  a_trim_high_zero: assert property (
    $past(reg_read) && $past(reg_addr) == 3'h4 |-> reg_rdata[7:3] == 5'h00)
    else $error("Upper trim bits not zero.");
  a_ref_buf_follow: assert property (
    reg_write && reg_addr == 3'h0
    |=> reference_buffer_enable == $past(reg_wdata[0]))
    else $error("Reference buffer enable wrong.");
  a_trip_follow: assert property (
    reg_write && reg_addr == 3'h2
    |=> {detect_trip_select, warning_trip_select} == $past(reg_wdata[5:4]))
    else $error("Trip selects wrong.");
  a_irq_sticky: assert property (
    undervolt_irq && !reg_write |=> undervolt_irq)
    else $error("Interrupt dropped without a write.");
  a_reset_sticky: assert property (
    undervolt_reset && !reg_write |=> undervolt_reset)
    else $error("Reset request dropped without a write.");
  a_pd_first_write: assert property (
    reg_write && reg_addr == 3'h1 && !pd_used_reg
    |=> {deep_sleep_allow, deep_sleep_kind_select} == $past(reg_wdata[1:0]))
    else $error("First power-down write not taken.");
  a_pd_write_once: assert property (
    reg_write && reg_addr == 3'h1 && pd_used_reg
    |=> $stable({deep_sleep_allow, deep_sleep_kind_select}))
    else $error("Write-once field changed.");
endmodule
bind pmsc_top pmsc_checker i_chk (.*);

// file: dv/pmsc_far_model.sv
// Far side model: supply comparators, stop controller and trim flash.
module pmsc_far_model #(
  parameter logic [7:0] TRIM_LOW  = 8'hA5,
  parameter logic [2:0] TRIM_HIGH = 3'h6
) (
  input  wire logic       clock,
  input  wire logic       supply_low,
  input  wire logic       supply_warn,
  input  wire logic       sleep_req,
  input  wire logic       deep_sleep_allow,
  input  wire logic       deep_sleep_kind_select,
  output logic            undervolt_detect_in,
  output logic            undervolt_warning_in,
  output logic            stop_active,
  output logic            full_sleep_exit,
  output logic            partial_sleep_exit,
  output logic      [7:0] trim_flash_low,
  output logic      [2:0] trim_flash_high
);
  int stop_cnt = 0;
  assign trim_flash_low  = TRIM_LOW;
  assign trim_flash_high = TRIM_HIGH;
  assign stop_active     = stop_cnt != 0;
  initial begin
    {undervolt_detect_in, undervolt_warning_in} = 2'b00;
    {full_sleep_exit, partial_sleep_exit} = 2'b00;
  end
  // A stop lasts eight cycles; only a permitted power-down wakes with an
  // exit pulse, since a plain stop loses nothing to recover.
  always @(posedge clock) begin
    undervolt_detect_in  <= supply_low;
    undervolt_warning_in <= supply_warn;
    full_sleep_exit      <= 1'b0;
    partial_sleep_exit   <= 1'b0;
    if (sleep_req && stop_cnt == 0)
      stop_cnt <= 8;
    else if (stop_cnt > 1)
      stop_cnt <= stop_cnt - 1;
    else if (stop_cnt == 1) begin
      stop_cnt <= 0;
      full_sleep_exit    <= deep_sleep_allow && !deep_sleep_kind_select;
      partial_sleep_exit <= deep_sleep_allow && deep_sleep_kind_select;
    end
  end
endmodule

// file: dv/pmsc_top_bench.sv
// Self-checking bench for the power management status block.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module pmsc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] TL = 8'hA5;
  localparam logic [2:0] TH = 3'h6;
  logic       clock, rstn, reg_write, reg_read, supply_low, supply_warn;
  logic       sleep_req, undervolt_detect_in, undervolt_warning_in;
  logic       stop_active, full_sleep_exit, partial_sleep_exit;
  logic       undervolt_irq, undervolt_reset, reference_buffer_enable;
  logic       detect_trip_select, warning_trip_select, detector_on;
  logic       deep_sleep_allow, deep_sleep_kind_select;
  logic [2:0] reg_addr, trim_flash_high;
  logic [7:0] reg_wdata, reg_rdata, trim_flash_low, r;
  logic [1:0] trips;
  int         n_fail, check_count;
  int         seed = 32'h6E90C298;
  // Both trip selects side by side, so one compare covers them.
  assign trips = {detect_trip_select, warning_trip_select};
  pmsc_top i_dut (.*);
  pmsc_far_model #(.TRIM_LOW(TL), .TRIM_HIGH(TH)) i_far (.*);
  // Expected warning register: flag, zero clear bit, trip selects.
  function automatic logic [7:0] warn_exp(input logic f, input logic [7:0] d);
    return {f, 1'b0, d[5:4], 4'h0};
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {rstn, reg_write, reg_read, supply_low, supply_warn, sleep_req} = '0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    wait_n(2);
    rd_chk(3'h3, TL);
    rd_chk(3'h4, {5'h00, TH});
    wr(3'h3, 8'h00);
    rd_chk(3'h3, TL);
    wr(3'h1, 8'h07);
    `CHK({deep_sleep_allow, deep_sleep_kind_select}, 2'b11)
    rd_chk(3'h1, 8'h03);
    wr(3'h1, 8'h04);
    rd_chk(3'h1, 8'h03);
    wr(3'h0, 8'h3D);
    rd_chk(3'h0, 8'h3D);
    wr(3'h0, 8'h62);
    rd_chk(3'h0, 8'h3C);
    supply_low <= 1'b1;
    wait_n(6);
    `CHK({undervolt_irq, undervolt_reset}, 2'b11)
    rd_chk(3'h0, 8'hBC);
    supply_low <= 1'b0;
    wait_n(4);
    wr(3'h0, 8'h5C);
    rd_chk(3'h0, 8'h1C);
    `CHK({undervolt_irq, undervolt_reset}, 2'b00)
    sleep_req <= 1'b1;
    wait_n(1);
    sleep_req <= 1'b0;
    wait_n(4);
    `CHK(detector_on, 1'b1)
    wait_n(10);
    rd_chk(3'h1, 8'h0B);
    wr(3'h1, 8'h04);
    rd_chk(3'h1, 8'h03);
    supply_warn <= 1'b1;
    wait_n(5);
    wr(3'h2, 8'h40);
    rd_chk(3'h2, warn_exp(1'b1, 8'h00));
    supply_warn <= 1'b0;
    wait_n(5);
    wr(3'h2, 8'h70);
    rd_chk(3'h2, warn_exp(1'b0, 8'h30));
    for (int i = 0; i < 24; i++) begin
      r = 8'($random(seed));
      wr(3'h2, r);
      `CHK(trips, r[5:4])
      wr(3'(5 + i % 3), ~r);
      rd_chk(3'h2, warn_exp(1'b0, r));
      rd_chk(3'(5 + i % 3), 8'h00);
    end
    rstn <= 1'b0;
    wait_n(2);
    rstn <= 1'b1;
    wait_n(2);
    wr(3'h1, 8'h06);
    rd_chk(3'h1, 8'h02);
    sleep_req <= 1'b1;
    wait_n(1);
    sleep_req <= 1'b0;
    wait_n(14);
    rd_chk(3'h1, 8'h12);
    rstn <= 1'b0;
    wait_n(2);
    rstn <= 1'b1;
    wait_n(2);
    rd_chk(3'h1, 8'h10);
    wr(3'h1, 8'h04);
    rd_chk(3'h1, 8'h00);
    print_verdict();
  end
endmodule

// file: shared/pmsc_pkg.sv
// Package for the power management status and control block.
package pmsc_pkg;
  // Register word addresses on the plain register port.
  localparam logic [2:0] ADDR_DETECT_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_POWER_DOWN   = 3'h1;
  localparam logic [2:0] ADDR_WARNING_CTRL = 3'h2;
  localparam logic [2:0] ADDR_TRIM_LOW     = 3'h3;
  localparam logic [2:0] ADDR_TRIM_HIGH    = 3'h4;
  // Detect control register fields.
  localparam int DET_FLAG_BIT      = 7;
  localparam int DET_CLEAR_BIT     = 6;
  localparam int DET_IRQ_EN_BIT    = 5;
  localparam int DET_RESET_EN_BIT  = 4;
  localparam int DET_STOP_EN_BIT   = 3;
  localparam int DET_ENABLE_BIT    = 2;
  localparam int DET_REF_BUF_BIT   = 0;
  // Power-down control register fields.
  localparam int PD_FULL_FLAG_BIT  = 4;
  localparam int PD_PART_FLAG_BIT  = 3;
  localparam int PD_CLEAR_BIT      = 2;
  localparam int PD_ALLOW_BIT      = 1;
  localparam int PD_KIND_BIT       = 0;
  // Warning control register fields.
  localparam int WARN_FLAG_BIT     = 7;
  localparam int WARN_CLEAR_BIT    = 6;
  localparam int WARN_DET_TRIP_BIT = 5;
  localparam int WARN_TRIP_BIT     = 4;
  // Reset values and widths.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int TRIM_HIGH_BITS    = 3;
endpackage

// file: verilog/pmsc_top.sv
// Power management status and control registers with detect and sleep logic.
// Behaviour
// - Detect flag, bit 7, sets on undervolt event only while enabled.
// - Writing 1 to detect clear bit 6 clears detect flag; reads zero.
// - Interrupt enable bit 5 with flag set requests an interrupt.
// - Reset enable bit 4 with detection enabled makes set flag force reset.
// - Stop enable bit 3 keeps detection running during stop mode.
// - Detect enable bit 2 switches detection, gates flag, irq, reset, stop.
// - Bit 0 of detect control enables the reference buffer.
// - Full power-down flag, bit 4, reads 1 after full power-down recovery.
// - Partial power-down flag, bit 3, sets on partial power-down exit.
// - Writing 1 to sleep clear bit 2 clears both recovery flags.
// - Power-down bit 1 permits power-down stop modes when 1.
// - Kind select bit 0 picks full (0) or partial (1) power-down.
// - Write-once control bits accept only the first write after reset.
// - Full recovery flag survives reset; only sleep clear bit clears it.
// - Warning flag bit 7 sets below warning trip, also after reset.
// - Warning clear bit 6 clears flag only when warning condition gone.
// - Warning register bit 5 selects detect trip point, low or high.
// - Warning register bit 4 selects warning trip point, low or high.
// - Low trim copy loads eight factory trim bits after every reset.
// - High trim copy holds three trim bits in 2..0; bits 7..3 read zero.
//
// The address-and-strobe port and the address map were chosen for this implementation.
module pmsc_top (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       undervolt_detect_in,
  input  wire logic       undervolt_warning_in,
  input  wire logic       stop_active,
  input  wire logic       full_sleep_exit,
  input  wire logic       partial_sleep_exit,
  input  wire logic [7:0] trim_flash_low,
  input  wire logic [2:0] trim_flash_high,
  output logic            undervolt_irq,
  output logic            undervolt_reset,
  output logic            reference_buffer_enable,
  output logic            detect_trip_select,
  output logic            warning_trip_select,
  output logic            deep_sleep_allow,
  output logic            deep_sleep_kind_select,
  output logic            detector_on
);

  // All state of the block except the full recovery flag lives in one packed struct.
  typedef struct packed {
    logic [1:0] det_sync;
    logic [1:0] warn_sync;
    logic [1:0] stop_sync;
    logic [1:0] full_sync;
    logic [1:0] part_sync;
    logic       undervolt_detect_flag;
    logic       undervolt_irq_enable;
    logic       undervolt_reset_enable;
    logic       undervolt_stop_enable;
    logic       undervolt_detect_enable;
    logic       reference_buffer_enable;
    logic       partial_sleep_recovered_flag;
    logic       deep_sleep_allow;
    logic       deep_sleep_kind_select;
    logic       det_ctrl_written;
    logic       pd_ctrl_written;
    logic       undervolt_warning_flag;
    logic       detect_trip_select;
    logic       warning_trip_select;
    logic [7:0] trim_copy_low;
    logic [2:0] trim_copy_high;
    logic       trim_loaded;
    logic [7:0] rdata;
    logic       irq;
    logic       rst_req;
    logic       det_on;
  } pmsc_state_t;

  pmsc_state_t state_reg;
  pmsc_state_t state_next;

  // The full recovery flag lives outside the reset domain so it survives it.
  logic full_flag_reg;
  logic full_flag_next;

  logic wr_det;
  logic wr_pd;
  logic wr_warn;
  logic det_active;

  // Write decode helper, used for every writable register.
  function automatic logic wr_hit(input logic       we,
                                  input logic [2:0] addr,
                                  input logic [2:0] target);
    return we && (addr == target);
  endfunction

  assign wr_det  = wr_hit(reg_write, reg_addr, pmsc_pkg::ADDR_DETECT_CTRL);
  assign wr_pd   = wr_hit(reg_write, reg_addr, pmsc_pkg::ADDR_POWER_DOWN);
  assign wr_warn = wr_hit(reg_write, reg_addr, pmsc_pkg::ADDR_WARNING_CTRL);

  // Detection runs when enabled, and in stop only if stop enable is set.
  assign det_active = state_reg.undervolt_detect_enable &&
                      (!state_reg.stop_sync[1] ||
                       state_reg.undervolt_stop_enable);

  // Full recovery flag: set wins over the acknowledge strobe.
  always_comb begin
    full_flag_next = full_flag_reg;
    if (wr_pd && reg_wdata[pmsc_pkg::PD_CLEAR_BIT]) begin
      full_flag_next = 1'b0;
    end
    if (state_reg.full_sync[1]) begin
      full_flag_next = 1'b1;
    end
  end

  // Next-state logic for registers, flags, outputs and read data.
  always_comb begin
    state_next = state_reg;
    // Pin inputs pass two flops; only the second stage is read.
    state_next.det_sync  = {state_reg.det_sync[0], undervolt_detect_in};
    state_next.warn_sync = {state_reg.warn_sync[0], undervolt_warning_in};
    state_next.stop_sync = {state_reg.stop_sync[0], stop_active};
    state_next.full_sync = {state_reg.full_sync[0], full_sleep_exit};
    state_next.part_sync = {state_reg.part_sync[0], partial_sleep_exit};

    // Trim copies load once right after reset release.
    if (!state_reg.trim_loaded) begin
      state_next.trim_copy_low  = trim_flash_low;
      state_next.trim_copy_high = trim_flash_high;
      state_next.trim_loaded    = 1'b1;
    end

    // Detect control writes; the write-once latch blocks later writes to the reset, stop and detect enables.
    if (wr_det) begin
      if (!state_reg.det_ctrl_written) begin
        state_next.det_ctrl_written       = 1'b1;
        state_next.undervolt_reset_enable =
          reg_wdata[pmsc_pkg::DET_RESET_EN_BIT];
        state_next.undervolt_stop_enable  =
          reg_wdata[pmsc_pkg::DET_STOP_EN_BIT];
        state_next.undervolt_detect_enable =
          reg_wdata[pmsc_pkg::DET_ENABLE_BIT];
      end
      state_next.undervolt_irq_enable    =
        reg_wdata[pmsc_pkg::DET_IRQ_EN_BIT];
      state_next.reference_buffer_enable =
        reg_wdata[pmsc_pkg::DET_REF_BUF_BIT];
      if (reg_wdata[pmsc_pkg::DET_CLEAR_BIT]) begin
        state_next.undervolt_detect_flag = 1'b0;
      end
    end
    // An event in the clearing cycle still sets the flag.
    if (det_active && state_reg.det_sync[1]) begin
      state_next.undervolt_detect_flag = 1'b1;
    end

    // Power-down control; allow and kind are write-once.
    if (wr_pd) begin
      if (!state_reg.pd_ctrl_written) begin
        state_next.pd_ctrl_written = 1'b1;
        state_next.deep_sleep_allow = reg_wdata[pmsc_pkg::PD_ALLOW_BIT];
        state_next.deep_sleep_kind_select =
          reg_wdata[pmsc_pkg::PD_KIND_BIT];
      end
      if (reg_wdata[pmsc_pkg::PD_CLEAR_BIT]) begin
        state_next.partial_sleep_recovered_flag = 1'b0;
      end
    end
    if (state_reg.part_sync[1]) begin
      state_next.partial_sleep_recovered_flag = 1'b1;
    end

    // Warning control: the clear only takes once the condition is gone.
    if (wr_warn) begin
      state_next.detect_trip_select =
        reg_wdata[pmsc_pkg::WARN_DET_TRIP_BIT];
      state_next.warning_trip_select =
        reg_wdata[pmsc_pkg::WARN_TRIP_BIT];
      if (reg_wdata[pmsc_pkg::WARN_CLEAR_BIT] && !state_reg.warn_sync[1])
      begin
        state_next.undervolt_warning_flag = 1'b0;
      end
    end
    // Level sensing also catches a supply already low after reset.
    if (state_reg.warn_sync[1]) begin
      state_next.undervolt_warning_flag = 1'b1;
    end

    // Interrupt and reset requests follow the flag and its enables.
    state_next.irq = state_next.undervolt_detect_flag &&
                     state_next.undervolt_irq_enable &&
                     state_next.undervolt_detect_enable;
    state_next.rst_req = state_next.undervolt_detect_flag &&
                         state_next.undervolt_reset_enable &&
                         state_next.undervolt_detect_enable;
    state_next.det_on = state_next.undervolt_detect_enable &&
                        (!state_next.stop_sync[1] ||
                         state_next.undervolt_stop_enable);

    // Read data stands in the cycle after the strobe only.
    state_next.rdata = pmsc_pkg::RESET_BYTE;
    if (reg_read) begin
      unique case (reg_addr)
        pmsc_pkg::ADDR_DETECT_CTRL: begin
          state_next.rdata[pmsc_pkg::DET_FLAG_BIT] =
            state_reg.undervolt_detect_flag;
          state_next.rdata[pmsc_pkg::DET_IRQ_EN_BIT] =
            state_reg.undervolt_irq_enable;
          state_next.rdata[pmsc_pkg::DET_RESET_EN_BIT] =
            state_reg.undervolt_reset_enable;
          state_next.rdata[pmsc_pkg::DET_STOP_EN_BIT] =
            state_reg.undervolt_stop_enable;
          state_next.rdata[pmsc_pkg::DET_ENABLE_BIT] =
            state_reg.undervolt_detect_enable;
          state_next.rdata[pmsc_pkg::DET_REF_BUF_BIT] =
            state_reg.reference_buffer_enable;
        end
        pmsc_pkg::ADDR_POWER_DOWN: begin
          state_next.rdata[pmsc_pkg::PD_FULL_FLAG_BIT] = full_flag_reg;
          state_next.rdata[pmsc_pkg::PD_PART_FLAG_BIT] =
            state_reg.partial_sleep_recovered_flag;
          state_next.rdata[pmsc_pkg::PD_ALLOW_BIT] =
            state_reg.deep_sleep_allow;
          state_next.rdata[pmsc_pkg::PD_KIND_BIT] =
            state_reg.deep_sleep_kind_select;
        end
        pmsc_pkg::ADDR_WARNING_CTRL: begin
          state_next.rdata[pmsc_pkg::WARN_FLAG_BIT] =
            state_reg.undervolt_warning_flag;
          state_next.rdata[pmsc_pkg::WARN_DET_TRIP_BIT] =
            state_reg.detect_trip_select;
          state_next.rdata[pmsc_pkg::WARN_TRIP_BIT] =
            state_reg.warning_trip_select;
        end
        pmsc_pkg::ADDR_TRIM_LOW: begin
          state_next.rdata = state_reg.trim_copy_low;
        end
        pmsc_pkg::ADDR_TRIM_HIGH: begin
          state_next.rdata[pmsc_pkg::TRIM_HIGH_BITS-1:0] =
            state_reg.trim_copy_high;
        end
        default: begin
          state_next.rdata = pmsc_pkg::RESET_BYTE;
        end
      endcase
    end
  end

  // Synchronous reset clears every bit of state_reg to a constant.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Kept out of reset on purpose: the flag must report recovery across it.
  always_ff @(posedge clock) begin
    full_flag_reg <= full_flag_next;
  end

  // Outputs come straight from state flip-flops.
  assign reg_rdata               = state_reg.rdata;
  assign undervolt_irq           = state_reg.irq;
  assign undervolt_reset         = state_reg.rst_req;
  assign reference_buffer_enable = state_reg.reference_buffer_enable;
  assign detect_trip_select      = state_reg.detect_trip_select;
  assign warning_trip_select     = state_reg.warning_trip_select;
  assign deep_sleep_allow        = state_reg.deep_sleep_allow;
  assign deep_sleep_kind_select  = state_reg.deep_sleep_kind_select;
  assign detector_on             = state_reg.det_on;

endmodule
